// >>> hdl/txc_map.vh
`ifndef TXC_MAP_VH
`define TXC_MAP_VH

// core clock and start-up timing
`define TXC_CLK_PERIOD_NS 10
`define TXC_TON_NS        1000
`define TXC_TON_CYC       ((`TXC_TON_NS + `TXC_CLK_PERIOD_NS - 1) / `TXC_CLK_PERIOD_NS)

// mode states
`define TXC_ST_STANDBY 2'h0
`define TXC_ST_STARTUP 2'h1
`define TXC_ST_ACTIVE  2'h2

// register byte addresses
`define TXC_ADR_CTRL   8'h00
`define TXC_ADR_STATUS 8'h04
`define TXC_ADR_EVENTS 8'h08
`define TXC_ADR_ID     8'h0C

// control fields and reset value
`define TXC_CTRL_INHIBIT 0
`define TXC_CTRL_RST     1'h0

// status fields
`define TXC_STAT_MODE_LSB  0
`define TXC_STAT_MODE_MSB  1
`define TXC_STAT_LOCK      2
`define TXC_STAT_LOWV      3
`define TXC_STAT_THERM_LSB 4
`define TXC_STAT_THERM_MSB 7
`define TXC_STAT_STEP_LSB  8
`define TXC_STAT_STEP_MSB  10
`define TXC_STAT_PAON      11

// sticky event fields
`define TXC_EVT_LOCKLOST 0
`define TXC_EVT_LOWV     1

// identification value, arbitrary
`define TXC_ID_VALUE 32'h00C0FFEE

// clock divider terminal counts, one below the half period in core cycles
`define TXC_HALF_DIV4  3'h1
`define TXC_HALF_DIV16 3'h7

`endif

// >>> hdl/txc_pin_sync.v
`timescale 1ns/10ps
// three-stage pin synchroniser, output moves once stages two and three agree
module txc_pin_sync #(
  parameter WIDTH    = 1,
  parameter RESETVAL = 1'b0
) (
  input  wire             clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] pinIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1_r;
  reg [WIDTH-1:0] stage2_r;
  reg [WIDTH-1:0] stage3_r;
  integer         i;

  // synchroniser chain and agreement filter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_r <= {WIDTH{RESETVAL}};
      stage2_r <= {WIDTH{RESETVAL}};
      stage3_r <= {WIDTH{RESETVAL}};
      syncOut  <= {WIDTH{RESETVAL}};
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2_r[i] == stage3_r[i]) begin
          syncOut[i] <= stage3_r[i];
        end
      end
    end
  end

endmodule

// >>> hdl/txc_clk_div.v
`timescale 1ns/10ps
`include "txc_map.vh"
// reference divider for the host clock output, divide by 4 or 16
module txc_clk_div (
  input  wire clk,
  input  wire rst,
  input  wire run,
  input  wire divSel,
  output reg  clkOut
);

  reg  [2:0] halfCnt_r;
  reg        divSelLatched_r;
  wire [2:0] halfLimit;

  assign halfLimit = divSelLatched_r ? `TXC_HALF_DIV16 : `TXC_HALF_DIV4;

  // toggle at each half period, ratio change taken at a half-period boundary
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      halfCnt_r       <= 3'h0;
      divSelLatched_r <= 1'b0;
      clkOut          <= 1'b0;
    end else if (!run) begin
      halfCnt_r       <= 3'h0;
      divSelLatched_r <= divSel;
      clkOut          <= 1'b0;
    end else if (halfCnt_r == halfLimit) begin
      halfCnt_r       <= 3'h0;
      divSelLatched_r <= divSel;
      clkOut          <= ~clkOut;
    end else begin
      halfCnt_r <= halfCnt_r + 3'h1;
    end
  end

endmodule

// >>> hdl/txc_mode_ctrl.v
`timescale 1ns/10ps
`include "txc_map.vh"
module txc_mode_ctrl (
  input  wire        core_clk,
  input  wire        sys_rst,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire        txEnablePin,
  input  wire        clockDivideSelect,
  input  wire        shiftKeyingDataIn,
  input  wire [3:0]  pselCompIn,
  input  wire        pllLockIn,
  input  wire        lowVoltIn,
  output reg         txActive,
  output reg         pselSenseEn,
  output reg  [3:0]  paCurrentEn,
  output reg  [2:0]  powerStep,
  output reg         oscLowFreqSel,
  output wire        dividedClockOut
);

  localparam integer TON_CYC_FULL = `TXC_TON_CYC;
  localparam [15:0]  TON_CYC      = TON_CYC_FULL[15:0];

  // synchronised pin levels
  wire       enSync;
  wire       divSelSync;
  wire       fskSync;
  wire [3:0] thermSync;
  wire       lockSync;
  wire       lowVSync;

  // mode state and start-up timer
  reg  [1:0]  state_r;
  reg  [1:0]  state_nxt;
  reg  [15:0] startCnt_r;
  reg  [15:0] startCnt_nxt;

  // software registers
  reg         ctrlInhibit_r;
  reg  [1:0]  events_r;
  reg  [1:0]  events_nxt;
  reg  [31:0] rdData;

  // derived power control terms
  wire        enableReq;
  wire        paGate;
  wire [3:0]  thermUsed;
  reg  [2:0]  stepCount;
  wire        busReq;
  wire        busWrite;
  wire        lockLostEvt;
  wire        lowVEvt;
  integer     k;

  // enable pin resets low, so a floating pad with its pull-down reads as standby
  txc_pin_sync #(
    .WIDTH    (1),
    .RESETVAL (1'b0)
  ) u_sync_en (
    .clk     (core_clk),
    .rst     (sys_rst),
    .pinIn   (txEnablePin),
    .syncOut (enSync)
  );

  // divider select and keying data
  txc_pin_sync #(
    .WIDTH    (2),
    .RESETVAL (1'b0)
  ) u_sync_ctl (
    .clk     (core_clk),
    .rst     (sys_rst),
    .pinIn   ({clockDivideSelect, shiftKeyingDataIn}),
    .syncOut ({divSelSync, fskSync})
  );

  // four power-select comparator outputs
  txc_pin_sync #(
    .WIDTH    (4),
    .RESETVAL (1'b0)
  ) u_sync_therm (
    .clk     (core_clk),
    .rst     (sys_rst),
    .pinIn   (pselCompIn),
    .syncOut (thermSync)
  );

  // lock and low-voltage flags, both start in the blocking state
  txc_pin_sync #(
    .WIDTH    (1),
    .RESETVAL (1'b0)
  ) u_sync_lock (
    .clk     (core_clk),
    .rst     (sys_rst),
    .pinIn   (pllLockIn),
    .syncOut (lockSync)
  );

  txc_pin_sync #(
    .WIDTH    (1),
    .RESETVAL (1'b1)
  ) u_sync_lowv (
    .clk     (core_clk),
    .rst     (sys_rst),
    .pinIn   (lowVoltIn),
    .syncOut (lowVSync)
  );

  // enable request after the software inhibit
  assign enableReq = enSync & ~ctrlInhibit_r;

  // mode state machine with start-up wait
  always @* begin
    state_nxt    = state_r;
    startCnt_nxt = startCnt_r;
    case (state_r)
      `TXC_ST_STANDBY: begin
        startCnt_nxt = 16'h0000;
        if (enableReq) begin
          state_nxt = `TXC_ST_STARTUP;
        end
      end
      `TXC_ST_STARTUP: begin
        if (!enableReq) begin
          state_nxt    = `TXC_ST_STANDBY;
          startCnt_nxt = 16'h0000;
        end else if (startCnt_r < TON_CYC) begin
          startCnt_nxt = startCnt_r + 16'h0001;
        end else if (lockSync) begin
          state_nxt = `TXC_ST_ACTIVE;
        end
      end
      `TXC_ST_ACTIVE: begin
        if (!enableReq) begin
          state_nxt    = `TXC_ST_STANDBY;
          startCnt_nxt = 16'h0000;
        end
      end
      default: begin
        state_nxt    = `TXC_ST_STANDBY;
        startCnt_nxt = 16'h0000;
      end
    endcase
  end

  // state registers
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r    <= `TXC_ST_STANDBY;
      startCnt_r <= 16'h0000;
    end else begin
      state_r    <= state_nxt;
      startCnt_r <= startCnt_nxt;
    end
  end

  // amplifier gate: active and still enabled, locked and supply good
  // enable dropping closes the gate on the same edge the sense path turns off
  assign paGate = (state_r == `TXC_ST_ACTIVE) & enableReq & lockSync & ~lowVSync;

  // comparator code ignored while the sense path is off
  assign thermUsed = pselSenseEn ? thermSync : 4'h0;

  // count of set thermometer bits
  always @* begin
    stepCount = 3'h0;
    for (k = 0; k < 4; k = k + 1) begin
      stepCount = stepCount + {2'h0, thermUsed[k]};
    end
  end

  // transmit path outputs
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      txActive      <= 1'b0;
      pselSenseEn   <= 1'b0;
      paCurrentEn   <= 4'h0;
      powerStep     <= 3'h0;
      oscLowFreqSel <= 1'b0;
    end else begin
      txActive    <= (state_nxt != `TXC_ST_STANDBY);
      pselSenseEn <= (state_nxt != `TXC_ST_STANDBY);
      // each code bit drives one weighted source
      paCurrentEn <= paGate ? thermUsed : 4'h0;
      powerStep   <= paGate ? stepCount : 3'h0;
      // pull switch closed for data 0 while running
      oscLowFreqSel <= (state_nxt != `TXC_ST_STANDBY) & ~fskSync;
    end
  end

  // host clock output runs outside standby
  txc_clk_div u_clk_div (
    .clk    (core_clk),
    .rst    (sys_rst),
    .run    (txActive),
    .divSel (divSelSync),
    .clkOut (dividedClockOut)
  );

  // bus request qualification, a write lands on the edge where the master samples ack
  assign busReq   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign busWrite = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];

  // sticky events: lock dropped while active, supply trip while running
  assign lockLostEvt = (state_r == `TXC_ST_ACTIVE) & ~lockSync;
  assign lowVEvt     = (state_r != `TXC_ST_STANDBY) & lowVSync;

  // write-one-to-clear, a new event wins over the clear
  always @* begin
    events_nxt = events_r;
    if (busWrite && (wb_adr_i == `TXC_ADR_EVENTS)) begin
      events_nxt = events_r & ~wb_dat_i[`TXC_EVT_LOWV:`TXC_EVT_LOCKLOST];
    end
    if (lockLostEvt) begin
      events_nxt[`TXC_EVT_LOCKLOST] = 1'b1;
    end
    if (lowVEvt) begin
      events_nxt[`TXC_EVT_LOWV] = 1'b1;
    end
  end

  // control and event registers
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrlInhibit_r <= `TXC_CTRL_RST;
      events_r      <= 2'h0;
    end else begin
      events_r <= events_nxt;
      if (busWrite && (wb_adr_i == `TXC_ADR_CTRL)) begin
        ctrlInhibit_r <= wb_dat_i[`TXC_CTRL_INHIBIT];
      end
    end
  end

  // read multiplexer, unmapped words read zero
  always @* begin
    rdData = 32'h00000000;
    case (wb_adr_i)
      `TXC_ADR_CTRL: begin
        rdData[`TXC_CTRL_INHIBIT] = ctrlInhibit_r;
      end
      `TXC_ADR_STATUS: begin
        rdData[`TXC_STAT_MODE_MSB:`TXC_STAT_MODE_LSB]   = state_r;
        rdData[`TXC_STAT_LOCK]                          = lockSync;
        rdData[`TXC_STAT_LOWV]                          = lowVSync;
        rdData[`TXC_STAT_THERM_MSB:`TXC_STAT_THERM_LSB] = thermUsed;
        rdData[`TXC_STAT_STEP_MSB:`TXC_STAT_STEP_LSB]   = powerStep;
        rdData[`TXC_STAT_PAON]                          = |paCurrentEn;
      end
      `TXC_ADR_EVENTS: begin
        rdData[`TXC_EVT_LOWV:`TXC_EVT_LOCKLOST] = events_r;
      end
      `TXC_ADR_ID: begin
        rdData = `TXC_ID_VALUE;
      end
      default: begin
        rdData = 32'h00000000;
      end
    endcase
  end

  // classic single-cycle answer, ack one cycle then dropped
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= busReq;
      if (busReq && !wb_we_i) begin
        wb_dat_o <= rdData;
      end
    end
  end

endmodule

// >>> bench/txc_mode_ctrl_checker.sv
`timescale 1ns/10ps
module txc_mode_ctrl_checker (
  input wire       core_clk,
  input wire       sys_rst,
  input wire       wb_cyc_i,
  input wire       wb_stb_i,
  input wire       wb_ack_o,
  input wire       txEnablePin,
  input wire       pllLockIn,
  input wire       lowVoltIn,
  input wire       txActive,
  input wire       pselSenseEn,
  input wire [3:0] paCurrentEn,
  input wire [2:0] powerStep,
  input wire       oscLowFreqSel,
  input wire       dividedClockOut
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  // power outputs agree and follow the thermometer shape
  AST_STEP: assert property (powerStep == $countones(paCurrentEn))
    else $error("power step differs from source count");
  AST_THERM: assert property (paCurrentEn inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
    else $error("amplifier sources not thermometer coded");
  // gating by lock and supply
  AST_LOCK: assert property (!pllLockIn [*7] |-> paCurrentEn == 4'h0)
    else $error("amplifier on without lock");
  AST_LOWV: assert property (lowVoltIn [*7] |-> paCurrentEn == 4'h0)
    else $error("amplifier on at low supply");
  // standby behaviour
  AST_STBY: assert property (!txEnablePin [*8] |-> !txActive && !pselSenseEn)
    else $error("not in standby with enable low");
  AST_SENSE: assert property (!pselSenseEn |-> paCurrentEn == 4'h0 && powerStep == 3'h0)
    else $error("power applied with sense path off");
  AST_CLK: assert property (!txActive [*2] |-> !dividedClockOut)
    else $error("clock output runs in standby");
  AST_OSC: assert property (oscLowFreqSel |-> txActive)
    else $error("pull switch closed in standby");
  // bus answer timing
  AST_ACK: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  AST_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
endmodule
bind txc_mode_ctrl txc_mode_ctrl_checker u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .txEnablePin(txEnablePin), .pllLockIn(pllLockIn),
  .lowVoltIn(lowVoltIn), .txActive(txActive), .pselSenseEn(pselSenseEn), .paCurrentEn(paCurrentEn),
  .powerStep(powerStep), .oscLowFreqSel(oscLowFreqSel), .dividedClockOut(dividedClockOut));

// >>> bench/txc_host_model.sv
`timescale 1ns/10ps
module txc_host_model (
  input  wire       core_clk,
  input  wire       paOn,
  output reg        txEnablePin,
  output reg        clockDivideSelect,
  output reg        shiftKeyingDataIn,
  output reg  [3:0] pselCompIn
);
  // pins idle at time zero
  initial begin
    txEnablePin = 1'b0;
    clockDivideSelect = 1'b0;
    shiftKeyingDataIn = 1'b1;
    pselCompIn = 4'h0;
  end
  // enable, divider and power level move on a clock edge
  task drive(input en, input div, input [3:0] lvl);
    begin
      @(posedge core_clk);
      txEnablePin <= en;
      clockDivideSelect <= div;
      pselCompIn <= lvl;
    end
  endtask
  // keyed data only once the carrier is on
  task key(input b);
    begin
      while (paOn !== 1'b1) begin
        @(posedge core_clk);
      end
      @(posedge core_clk);
      shiftKeyingDataIn <= b;
    end
  endtask
  // on-off keying straight onto the power-select level
  task ask(input b);
    begin
      @(posedge core_clk);
      pselCompIn <= b ? 4'hF : 4'h0;
    end
  endtask
endmodule

// >>> bench/txc_mode_ctrl_tb_top.sv
`timescale 1ns/10ps
`include "txc_map.vh"
module txc_mode_ctrl_tb_top;
  reg         core_clk, sys_rst, wbCyc, wbStb, wbWe, pllLock, lowVolt;
  reg  [7:0]  wbAdr;
  reg  [31:0] wbDatI, rd;
  wire [31:0] wbDatO;
  wire        wbAck, txEnablePin, clockDivideSelect, shiftKeyingDataIn, txActive, pselSenseEn;
  wire        oscLowFreqSel, dividedClockOut;
  wire [3:0]  pselCompIn, paCurrentEn;
  wire [2:0]  powerStep;
  integer     bad_count, n_checks, k, p;
  reg  [4:0]  th;
  txc_mode_ctrl DUT (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck), .txEnablePin(txEnablePin), .clockDivideSelect(clockDivideSelect),
    .shiftKeyingDataIn(shiftKeyingDataIn), .pselCompIn(pselCompIn), .pllLockIn(pllLock),
    .lowVoltIn(lowVolt), .txActive(txActive), .pselSenseEn(pselSenseEn), .paCurrentEn(paCurrentEn),
    .powerStep(powerStep), .oscLowFreqSel(oscLowFreqSel), .dividedClockOut(dividedClockOut));
  txc_host_model host (.core_clk(core_clk), .paOn(|paCurrentEn), .txEnablePin(txEnablePin),
    .clockDivideSelect(clockDivideSelect), .shiftKeyingDataIn(shiftKeyingDataIn), .pselCompIn(pselCompIn));
  // free-running core clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  // one classic wishbone cycle, read data taken at the ack edge
  task bus(input we, input [7:0] adr, input [31:0] dat);
    begin
      @(posedge core_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= we;
      wbAdr <= adr;
      wbDatI <= dat;
      @(posedge core_clk);
      while (wbAck !== 1'b1) begin
        @(posedge core_clk);
      end
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
    end
  endtask
  task tick(input integer n);
    begin
      repeat (n) @(posedge core_clk);
      #1;
    end
  endtask
  // cycles between two rising edges of the divided clock
  task period(output integer n);
    realtime t0;
    begin
      @(posedge dividedClockOut);
      t0 = $realtime;
      @(posedge dividedClockOut);
      n = ($realtime - t0) / 10.0;
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  // watchdog against a hang
  initial begin
    #60000;
    bad_count = bad_count + 1;
    results;
  end
  initial begin
    bad_count = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI} = 43'h0;
    pllLock = 1'b1;
    lowVolt = 1'b0;
    repeat (16) @(posedge core_clk);
    sys_rst <= 1'b0;
    bus(0, `TXC_ADR_ID, 0);
    chk(rd, `TXC_ID_VALUE);
    bus(0, 8'h10, 0);
    chk(rd, 32'h0);
    host.drive(0, 0, 4'hF);
    tick(20);
    chk({txActive, pselSenseEn, paCurrentEn}, 6'h00);
    host.drive(1, 0, 4'hF);
    tick(10);
    chk({txActive, pselSenseEn}, 2'h3);
    period(p);
    chk(p, 4);
    tick(30);
    chk(paCurrentEn, 4'h0);
    host.drive(1, 1, 4'hF);
    period(p);
    period(p);
    chk(p, 16);
    tick(100);
    chk(paCurrentEn, 4'hF);
    // every power step in turn, changed while active
    for (k = 0; k < 5; k = k + 1) begin
      th = (5'h01 << k) - 5'h01;
      host.drive(1, 0, th[3:0]);
      tick(8);
      chk({powerStep, paCurrentEn}, {k[2:0], th[3:0]});
    end
    bus(0, `TXC_ADR_STATUS, 0);
    chk(rd[11:0], 12'hCF6);
    @(posedge core_clk);
    pllLock <= 1'b0;
    tick(8);
    chk(paCurrentEn, 4'h0);
    @(posedge core_clk);
    pllLock <= 1'b1;
    tick(8);
    chk(paCurrentEn, 4'hF);
    @(posedge core_clk);
    lowVolt <= 1'b1;
    tick(8);
    chk(powerStep, 3'h0);
    @(posedge core_clk);
    lowVolt <= 1'b0;
    host.key(0);
    tick(8);
    chk(oscLowFreqSel, 1'b1);
    host.key(1);
    tick(8);
    chk(oscLowFreqSel, 1'b0);
    host.ask(0);
    tick(8);
    chk(paCurrentEn, 4'h0);
    // sticky lock-lost and low-supply events, then write-one-to-clear
    bus(0, `TXC_ADR_EVENTS, 0);
    chk(rd, 32'h3);
    bus(1, `TXC_ADR_EVENTS, 32'h3);
    bus(0, `TXC_ADR_EVENTS, 0);
    chk(rd, 32'h0);
    bus(1, `TXC_ADR_CTRL, 1);
    tick(6);
    chk({txActive, dividedClockOut}, 2'h0);
    bus(0, `TXC_ADR_CTRL, 0);
    chk(rd, 32'h1);
    bus(1, `TXC_ADR_CTRL, 0);
    host.drive(0, 0, 4'hF);
    tick(12);
    chk({txActive, pselSenseEn, dividedClockOut}, 3'h0);
    results;
  end
endmodule
